//--- hdl/wdt_consts.vh
`ifndef WDT_CONSTS_VH
`define WDT_CONSTS_VH

// ==========================================================
// Register map
`define CPU_STATUS_ADDR   8'h06
`define CPU_STATUS_RESET  8'h3c
`define BIT_STACK_AVAIL   5
`define BIT_GLINT_DIS     4
`define BIT_TIMEOUT_N     3
`define BIT_POWERDOWN_N   2
`define BIT_POR_N         1
`define BIT_BOR_N         0

// ==========================================================
// Configuration encodings
`define WD_PERIOD_OFF     2'b00
`define WD_PERIOD_PS256   2'b01
`define WD_PERIOD_PS64    2'b10
`define WD_PERIOD_PS1     2'b11
`define PS_RATIO_256      9'h100
`define PS_RATIO_64       9'h040
`define PS_RATIO_1        9'h001
`define OSC_MODE_LF       2'b00
`define OSC_MODE_XT       2'b10
`define PM_CODE_PROTECT   3'b000

// ==========================================================
// Timing
`define WD_BASE_US        12000
`define RC_PERIOD_NS      1000
`define TIMER_OVF_TOSC    65536
`define OST_TOSC          1024
`define CLOCK_PERIOD_NS   8

`endif

//--- hdl/watchdog_sleep_wake_control.v
// Implementation choice: strobed register access.
`timescale 1ns/10ps
`include "wdt_consts.vh"

// How it works
// R1: Watchdog counts ticks of a free-running RC oscillator, also during sleep.
// R2: Watchdog time-out causes a full device reset, awake or asleep.
// R3: Period field 00 disables the watchdog for as long as the field holds 00.
// R4: Base period 12 ms, extended by a postscaler up to 1:256.
// R5: Counter and postscaler cleared in reset, on sleep, clear instruction, interrupt wake.
// R6: Counting starts on the first edge after reset release.
// R7: Time-out clears the active-low timeout flag.
// R8: The counter alone, one base period without the postscaler, serves as power-up delay after power-on.
// R9: Timer mode counts 65536 oscillator periods, clears timeout flag, no reset.
// R10: In timer mode the clear instruction sets the timeout flag.
// R11: In timer mode the counter holds still during sleep.
// R12: Software cannot read or write counter or postscaler.
// R13: Sleep clears power-down flag, sets timeout flag, stops oscillator, holds pins.
// R14: Watchdog reset never drives the master clear pin.
// R15: Reset events and enabled listed interrupts end sleep.
// R16: Reset wake resets the device; interrupt wake resumes execution.
// R17: Interrupt wakes only when its own enable is set, whatever the global disable.
// R18: On interrupt wake run next instruction, vector only if globals enabled.
// R19: Pending enabled interrupt at sleep wakes at once, flags left as sleep set.
// R20: Any wake clears the watchdog counter.
// R21: Crystal modes run a 1024-period start-up timer on wake; the code skips it on a wake by the clear pin.
// R22: Code-protected mode blocks program memory access from external fetches.
module watchdog_sleep_wake_control #(
  parameter BASE_TICKS = `WD_BASE_US * 1000 / `RC_PERIOD_NS,
  parameter TIMER_OVF  = `TIMER_OVF_TOSC
) (
  input  wire        clock,
  input  wire        nrst,
  input  wire        rc_osc_in,
  input  wire        master_clear_pin,
  input  wire [1:0]  wd_period_cfg,
  input  wire        wd_timer_mode,
  input  wire [1:0]  osc_mode_cfg,
  input  wire [2:0]  processor_mode_cfg,
  input  wire        sleep_instr,
  input  wire        clear_watchdog_instr,
  input  wire [10:0] int_enable,
  input  wire [10:0] int_flag,
  input  wire        fetch_internal,
  input  wire        pm_access_req,
  input  wire [7:0]  addr,
  input  wire [7:0]  wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [7:0]  rdata,
  output reg         device_reset,
  output reg         core_stall,
  output reg         osc_drive_en,
  output reg         io_hold,
  output reg         wake_resume,
  output reg         wake_vector,
  output reg         pm_access_grant,
  output reg         global_int_disable
);

  // ========================================================
  // States
  //   power-up : the counter times the power-up delay, device held in reset
  //   run      : core executes, watchdog counts
  //   sleep    : oscillator off, pins held, waiting for a wake event
  //   start-up : crystal settles before the core sees clocks again
  //   clear    : device held in reset until the clear pin is high
  localparam [4:0] ST_PWRUP = 5'b00001;
  localparam [4:0] ST_RUN   = 5'b00010;
  localparam [4:0] ST_SLEEP = 5'b00100;
  localparam [4:0] ST_OST   = 5'b01000;
  localparam [4:0] ST_MCLR  = 5'b10000;

  localparam [23:0] BASE_LAST  = BASE_TICKS - 1;
  localparam [23:0] TIMER_LAST = TIMER_OVF - 1;
  localparam [10:0] OST_LAST   = `OST_TOSC - 1;
  localparam [7:0]  STATUS_RESET = `CPU_STATUS_RESET;

  reg [4:0]  state;
  reg [23:0] wd_count;
  reg [8:0]  postscale;
  reg [10:0] ost_count;
  reg        ost_int_wake;
  reg        timeout_flag_n;
  reg        powerdown_flag_n;
  reg        stack_avail;
  reg        por_n;
  reg        bor_n;

  // ========================================================
  // Pin synchronisers, a change counts once stages two and three agree
  reg [2:0] rc_sync;
  reg [2:0] mc_sync;
  reg       rc_level;
  reg       mc_level;
  reg       rc_tick;

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rc_sync  <= 3'b000;
      rc_level <= 1'b0;
      rc_tick  <= 1'b0;
    end else begin
      rc_sync <= {rc_sync[1:0], rc_osc_in};
      rc_tick <= 1'b0;
      // A tick is one clock wide, so each RC period advances the count once;
      // the RC period must span several system clocks for its edges to be seen
      if (rc_sync[1] == rc_sync[2]) begin
        rc_level <= rc_sync[2];
        rc_tick  <= rc_sync[2] & ~rc_level;
      end
    end
  end

  // The clear pin idles high, so its stages start high and no false clear follows reset
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mc_sync  <= 3'b111;
      mc_level <= 1'b1;
    end else begin
      mc_sync <= {mc_sync[1:0], master_clear_pin};
      if (mc_sync[1] == mc_sync[2])
        mc_level <= mc_sync[2];
    end
  end

  // ========================================================
  // Wake sources, one enable and flag pair per source
  wire [10:0] wake_src;
  genvar      src;
  generate
    for (src = 0; src < 11; src = src + 1) begin : g_wake_src
      assign wake_src[src] = int_enable[src] & int_flag[src];
    end
  endgenerate

  // ========================================================
  // Counting terms
  reg [8:0] ps_ratio;
  always @* begin
    case (wd_period_cfg)
      `WD_PERIOD_PS256: ps_ratio = `PS_RATIO_256;
      `WD_PERIOD_PS64:  ps_ratio = `PS_RATIO_64;
      default:          ps_ratio = `PS_RATIO_1;
    endcase
  end

  reg crystal;
  always @* begin
    case (osc_mode_cfg)
      `OSC_MODE_XT: crystal = 1'b1;
      `OSC_MODE_LF: crystal = 1'b1;
      default:      crystal = 1'b0;
    endcase
  end

  wire wd_enabled  = (wd_period_cfg != `WD_PERIOD_OFF);                  // R3
  wire wd_mode     = wd_enabled & ~wd_timer_mode;
  wire tm_mode     = wd_enabled & wd_timer_mode;
  wire base_done   = rc_tick & (wd_count == BASE_LAST);                    // R4
  wire wd_timeout  = wd_mode & base_done & (postscale == ps_ratio - 9'h001); // R4
  wire tm_overflow = tm_mode & (wd_count == TIMER_LAST);                  // R9
  wire wake_int    = |wake_src;                                           // R17
  wire pwrup_done  = base_done;                                           // R8

  // ========================================================
  // Main sequencer
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state              <= ST_PWRUP;
      wd_count           <= 24'h00_0000;                                  // R5
      postscale          <= 9'h000;
      ost_count          <= 11'h000;
      ost_int_wake       <= 1'b0;
      timeout_flag_n     <= STATUS_RESET[`BIT_TIMEOUT_N];
      powerdown_flag_n   <= STATUS_RESET[`BIT_POWERDOWN_N];
      stack_avail        <= STATUS_RESET[`BIT_STACK_AVAIL];
      global_int_disable <= STATUS_RESET[`BIT_GLINT_DIS];
      por_n              <= STATUS_RESET[`BIT_POR_N];
      bor_n              <= STATUS_RESET[`BIT_BOR_N];
      device_reset       <= 1'b1;
      core_stall         <= 1'b0;
      osc_drive_en       <= 1'b1;
      io_hold            <= 1'b0;
      wake_resume        <= 1'b0;
      wake_vector        <= 1'b0;
    end else begin
      wake_resume <= 1'b0;
      wake_vector <= 1'b0;
      // Software reaches only the status bits, never the counters   R12
      if (wr && addr == `CPU_STATUS_ADDR) begin
        global_int_disable <= wdata[`BIT_GLINT_DIS];
        por_n              <= wdata[`BIT_POR_N];
        bor_n              <= wdata[`BIT_BOR_N];
      end
      // Counter advances: RC ticks in watchdog mode, clocks in timer mode
      if (wd_mode || state == ST_PWRUP) begin                             // R1 R6
        if (rc_tick) begin
          if (base_done) begin
            wd_count  <= 24'h00_0000;
            postscale <= (postscale == ps_ratio - 9'h001) ? 9'h000 : postscale + 9'h001;
          end else
            wd_count <= wd_count + 24'h00_0001;
        end
      end else if (tm_mode && state != ST_SLEEP) begin                    // R11
        wd_count <= tm_overflow ? 24'h00_0000 : wd_count + 24'h00_0001;
      end
      if (tm_overflow && state == ST_RUN)
        timeout_flag_n <= 1'b0;                                           // R9
      case (state)
        ST_PWRUP: begin
          if (pwrup_done) begin
            state        <= ST_RUN;
            device_reset <= 1'b0;
            wd_count     <= 24'h00_0000;
            postscale    <= 9'h000;
          end
        end
        ST_RUN: begin
          if (!mc_level) begin
            state        <= ST_MCLR;
            device_reset <= 1'b1;
            wd_count     <= 24'h00_0000;
            postscale    <= 9'h000;
          end else if (wd_timeout) begin
            // Reset is internal only, the clear pin is never driven   R14
            timeout_flag_n <= 1'b0;                                       // R7
            device_reset   <= 1'b1;                                       // R2
            state          <= ST_MCLR;
            wd_count       <= 24'h00_0000;
            postscale      <= 9'h000;
          end else if (sleep_instr) begin
            wd_count         <= 24'h00_0000;                              // R5
            postscale        <= 9'h000;
            powerdown_flag_n <= 1'b0;                                     // R13
            timeout_flag_n   <= 1'b1;
            if (wake_int) begin
              wake_resume <= 1'b1;                                        // R19
              wake_vector <= ~global_int_disable;
            end else begin
              state        <= ST_SLEEP;
              osc_drive_en <= 1'b0;                                       // R13
              io_hold      <= 1'b1;
            end
          end else if (clear_watchdog_instr) begin
            wd_count  <= 24'h00_0000;                                     // R5
            postscale <= 9'h000;
            // A same-cycle overflow wins over the clear instruction
            if (tm_mode && !tm_overflow)
              timeout_flag_n <= 1'b1;                                     // R10
          end
        end
        ST_SLEEP: begin
          if (!mc_level || wd_timeout || wake_int) begin                  // R15
            wd_count     <= 24'h00_0000;                                  // R20
            postscale    <= 9'h000;
            osc_drive_en <= 1'b1;
            io_hold      <= 1'b0;
            ost_count    <= 11'h000;
            ost_int_wake <= mc_level & ~wd_timeout;                       // R16
            if (wd_timeout)
              timeout_flag_n <= 1'b0;                                     // R2
            if (!mc_level) begin
              state        <= ST_MCLR;
              device_reset <= 1'b1;
            end else if (crystal) begin
              state        <= ST_OST;                                     // R21
              core_stall   <= mc_level & ~wd_timeout;
              device_reset <= wd_timeout;
            end else if (wd_timeout) begin
              state        <= ST_MCLR;
              device_reset <= 1'b1;
            end else begin
              state       <= ST_RUN;
              wake_resume <= 1'b1;                                        // R18
              wake_vector <= ~global_int_disable;
            end
          end
        end
        ST_OST: begin
          // A watchdog wake also waits here with reset held, so the crystal is stable first
          ost_count <= ost_count + 11'h001;
          if (ost_count == OST_LAST) begin                                // R21
            state        <= ST_RUN;
            core_stall   <= 1'b0;
            device_reset <= 1'b0;
            wake_resume  <= ost_int_wake;                                 // R16 R18
            wake_vector  <= ost_int_wake & ~global_int_disable;
          end
        end
        ST_MCLR: begin
          // Held reset keeps the watchdog cleared until release   R5
          wd_count  <= 24'h00_0000;
          postscale <= 9'h000;
          if (mc_level) begin
            state        <= ST_RUN;
            device_reset <= 1'b0;
          end
        end
        default: begin
          state        <= ST_PWRUP;
          device_reset <= 1'b1;
        end
      endcase
    end
  end

  // ========================================================
  // Status register image, unused upper bits read as zero
  reg [7:0] status_word;
  always @* begin
    status_word                   = 8'h00;
    status_word[`BIT_STACK_AVAIL] = stack_avail;
    status_word[`BIT_GLINT_DIS]   = global_int_disable;
    status_word[`BIT_TIMEOUT_N]   = timeout_flag_n;
    status_word[`BIT_POWERDOWN_N] = powerdown_flag_n;
    status_word[`BIT_POR_N]       = por_n;
    status_word[`BIT_BOR_N]       = bor_n;
  end

  // ========================================================
  // Register read, zero whenever no status read was strobed
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= 8'h00;
      if (rd && addr == `CPU_STATUS_ADDR)
        rdata <= status_word;
    end
  end

  // ========================================================
  // Program memory guard, registered so the grant comes from a flip-flop
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pm_access_grant <= 1'b0;
    end else begin
      pm_access_grant <= pm_access_req &
                         ((processor_mode_cfg != `PM_CODE_PROTECT) | fetch_internal); // R22
    end
  end

endmodule // watchdog_sleep_wake_control

//--- verif/wdt_props.sv
`timescale 1ns/10ps
`include "wdt_consts.vh"
// ==========================================================
// Checker on the block's ports
module wdt_props #(
  parameter BASE_TICKS = 4,
  parameter TIMER_OVF  = 64
) (
  input wire        clock,
  input wire        nrst,
  input wire        rc_osc_in,
  input wire        master_clear_pin,
  input wire [1:0]  wd_period_cfg,
  input wire        wd_timer_mode,
  input wire [1:0]  osc_mode_cfg,
  input wire [2:0]  processor_mode_cfg,
  input wire        sleep_instr,
  input wire        clear_watchdog_instr,
  input wire [10:0] int_enable,
  input wire [10:0] int_flag,
  input wire        fetch_internal,
  input wire        pm_access_req,
  input wire [7:0]  addr,
  input wire [7:0]  wdata,
  input wire        wr,
  input wire        rd,
  input wire [7:0]  rdata,
  input wire        device_reset,
  input wire        core_stall,
  input wire        osc_drive_en,
  input wire        io_hold,
  input wire        wake_resume,
  input wire        wake_vector,
  input wire        pm_access_grant,
  input wire        global_int_disable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  wire pend = |(int_enable & int_flag);
  // Sleep only counts while the core really runs
  sequence s_sleep;
    sleep_instr && !device_reset && !core_stall;
  endsequence
  a_sleep_osc_off: assert property (s_sleep ##0 !pend |=> !osc_drive_en && io_hold)
    else $error("sleep left oscillator running");
  a_immediate_wake: assert property (s_sleep ##0 pend |=> wake_resume)
    else $error("pending interrupt did not wake at once");
  a_vector_globals: assert property (wake_vector |-> wake_resume && !global_int_disable)
    else $error("vector without enabled globals");
  a_resume_pulse: assert property (wake_resume |=> !wake_resume)
    else $error("resume pulse too long");
  a_asleep_pins: assert property (!osc_drive_en |-> io_hold)
    else $error("pins released while asleep");
  a_cp_block: assert property (processor_mode_cfg == 3'b000 && !fetch_internal && pm_access_req
                               |=> !pm_access_grant)
    else $error("external fetch granted in protected mode");
  a_cp_internal: assert property (pm_access_req && fetch_internal && !device_reset |=> pm_access_grant)
    else $error("internal fetch refused");
  a_unmapped_read: assert property (rd && addr != `CPU_STATUS_ADDR |=> rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule // wdt_props

bind watchdog_sleep_wake_control wdt_props #(.BASE_TICKS(BASE_TICKS), .TIMER_OVF(TIMER_OVF)) wdt_props_i (
  .clock(clock), .nrst(nrst), .rc_osc_in(rc_osc_in), .master_clear_pin(master_clear_pin),
  .wd_period_cfg(wd_period_cfg), .wd_timer_mode(wd_timer_mode), .osc_mode_cfg(osc_mode_cfg),
  .processor_mode_cfg(processor_mode_cfg), .sleep_instr(sleep_instr), .clear_watchdog_instr(clear_watchdog_instr),
  .int_enable(int_enable), .int_flag(int_flag), .fetch_internal(fetch_internal), .pm_access_req(pm_access_req),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .device_reset(device_reset),
  .core_stall(core_stall), .osc_drive_en(osc_drive_en), .io_hold(io_hold), .wake_resume(wake_resume),
  .wake_vector(wake_vector), .pm_access_grant(pm_access_grant), .global_int_disable(global_int_disable));

//--- verif/core_model.sv
`timescale 1ns/10ps
// ==========================================================
// Core stand-in: instructions arrive as one-cycle pulses
module core_model (
  input  wire  clock,
  output logic sleep_instr,
  output logic clear_watchdog_instr
);
  initial begin
    sleep_instr = 1'b0;
    clear_watchdog_instr = 1'b0;
  end
  task automatic exec_sleep();
    @(posedge clock);
    sleep_instr <= 1'b1;
    @(posedge clock);
    sleep_instr <= 1'b0;
  endtask
  task automatic exec_clear();
    @(posedge clock);
    clear_watchdog_instr <= 1'b1;
    @(posedge clock);
    clear_watchdog_instr <= 1'b0;
  endtask
endmodule // core_model

//--- verif/watchdog_sleep_wake_control_tb_top.sv
`timescale 1ns/10ps
`include "wdt_consts.vh"
module watchdog_sleep_wake_control_tb_top;
  logic        clock, nrst, rc_osc_in, wd_timer_mode, fetch_internal, pm_access_req, wr, rd;
  logic [1:0]  wd_period_cfg, osc_mode_cfg;
  logic        master_clear_pin;
  logic [2:0]  processor_mode_cfg;
  logic [10:0] int_enable, int_flag;
  logic [7:0]  addr, wdata, d;
  wire  [7:0]  rdata;
  wire         device_reset, core_stall, osc_drive_en, io_hold, wake_resume, wake_vector;
  wire         pm_access_grant, global_int_disable, sleep_instr, clear_watchdog_instr;
  int          num_errors, n_tests, i, hits;
  // Short counts keep the run brief
  watchdog_sleep_wake_control #(.BASE_TICKS(4), .TIMER_OVF(64)) watchdog_sleep_wake_control_i (
    .clock(clock), .nrst(nrst), .rc_osc_in(rc_osc_in), .master_clear_pin(master_clear_pin),
    .wd_period_cfg(wd_period_cfg),
    .wd_timer_mode(wd_timer_mode), .osc_mode_cfg(osc_mode_cfg), .processor_mode_cfg(processor_mode_cfg),
    .sleep_instr(sleep_instr), .clear_watchdog_instr(clear_watchdog_instr), .int_enable(int_enable),
    .int_flag(int_flag), .fetch_internal(fetch_internal), .pm_access_req(pm_access_req), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .device_reset(device_reset), .core_stall(core_stall),
    .osc_drive_en(osc_drive_en), .io_hold(io_hold), .wake_resume(wake_resume), .wake_vector(wake_vector),
    .pm_access_grant(pm_access_grant), .global_int_disable(global_int_disable));
  core_model core_model_i (.clock(clock), .sleep_instr(sleep_instr), .clear_watchdog_instr(clear_watchdog_instr));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Watchdog oscillator, unrelated in phase to the system clock
  initial begin
    rc_osc_in = 1'b0;
    forever #53 rc_osc_in = ~rc_osc_in;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick();
    @(posedge clock);
    #1;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic await_wake();
    for (i = 0; i < 50 && wake_resume !== 1'b1; i++) tick();
    check(wake_resume, 1'b1);
    if (wake_resume !== 1'b1) wrap_up();
  endtask
  task automatic t_power_up();
    repeat (20) tick();
    check(device_reset, 1'b1);
    for (i = 0; i < 400 && device_reset !== 1'b0; i++) tick();
    check(device_reset, 1'b0);
    if (device_reset !== 1'b0) wrap_up();
    reg_read(`CPU_STATUS_ADDR);
    check(d, `CPU_STATUS_RESET);
    reg_read(8'h07);
    check(d, 8'h00);
    $display("test power_up done");
  endtask
  task automatic t_sleep_wake();
    for (int g = 0; g < 2; g++) begin
      reg_write(`CPU_STATUS_ADDR, g ? 8'h03 : 8'h13);
      int_enable <= 11'h001;
      core_model_i.exec_sleep();
      tick();
      check({osc_drive_en, io_hold}, 8'h01);
      reg_read(`CPU_STATUS_ADDR);
      check(d[3:2], 2'b10);
      int_flag <= 11'h001;
      await_wake();
      check(wake_vector, g);
      int_flag <= 11'h000;
    end
    $display("test sleep_wake done");
  endtask
  task automatic t_pending_wake();
    int_flag <= 11'h001;
    core_model_i.exec_sleep();
    #1;
    await_wake();
    reg_read(`CPU_STATUS_ADDR);
    check(d[3:2], 2'b10);
    int_flag <= 11'h000;
    int_enable <= 11'h000;
    $display("test pending_wake done");
  endtask
  task automatic t_wd_timeout();
    wd_period_cfg <= `WD_PERIOD_PS1;
    core_model_i.exec_sleep();
    for (i = 0; i < 300 && device_reset !== 1'b1; i++) tick();
    check(device_reset, 1'b1);
    for (i = 0; i < 2000 && device_reset !== 1'b0; i++) tick();
    check(device_reset, 1'b0);
    if (device_reset !== 1'b0) wrap_up();
    wd_period_cfg <= `WD_PERIOD_OFF;
    check(osc_drive_en, 1'b1);
    reg_read(`CPU_STATUS_ADDR);
    check(d[3], 1'b0);
    hits = 0;
    for (i = 0; i < 300; i++) begin
      tick();
      if (device_reset !== 1'b0) hits++;
    end
    check(hits, 0);
    $display("test wd_timeout done");
  endtask
  task automatic t_timer_mode();
    wd_timer_mode <= 1'b1;
    wd_period_cfg <= `WD_PERIOD_PS1;
    core_model_i.exec_clear();
    reg_read(`CPU_STATUS_ADDR);
    check(d[3], 1'b1);
    hits = 0;
    for (i = 0; i < 80; i++) begin
      tick();
      if (device_reset !== 1'b0) hits++;
    end
    check(hits, 0);
    reg_read(`CPU_STATUS_ADDR);
    check(d[3], 1'b0);
    core_model_i.exec_clear();
    reg_read(`CPU_STATUS_ADDR);
    check(d[3], 1'b1);
    wd_period_cfg <= `WD_PERIOD_OFF;
    wd_timer_mode <= 1'b0;
    $display("test timer_mode done");
  endtask
  task automatic t_crystal_wake();
    osc_mode_cfg <= `OSC_MODE_XT;
    int_enable <= 11'h001;
    core_model_i.exec_sleep();
    int_flag <= 11'h001;
    repeat (2) tick();
    check(core_stall, 1'b1);
    hits = 0;
    for (i = 0; i < 1100 && wake_resume !== 1'b1; i++) begin
      tick();
      hits++;
    end
    check(core_stall, 1'b0);
    check(wake_resume, 1'b1);
    check(hits > `OST_TOSC - 8 && hits <= `OST_TOSC, 1'b1);
    if (wake_resume !== 1'b1) wrap_up();
    int_flag <= 11'h000;
    int_enable <= 11'h000;
    osc_mode_cfg <= 2'b01;
    $display("test crystal_wake done");
  endtask
  task automatic t_master_clear();
    @(posedge clock);
    master_clear_pin <= 1'b0;
    repeat (6) tick();
    check(device_reset, 1'b1);
    master_clear_pin <= 1'b1;
    repeat (6) tick();
    check(device_reset, 1'b0);
    $display("test master_clear done");
  endtask
  task automatic t_code_protect();
    for (int f = 0; f < 2; f++) begin
      @(posedge clock);
      processor_mode_cfg <= `PM_CODE_PROTECT;
      fetch_internal <= f;
      pm_access_req <= 1'b1;
      repeat (3) tick();
      check(pm_access_grant, f);
    end
    pm_access_req <= 1'b0;
    $display("test code_protect done");
  endtask
  initial begin
    num_errors = 0;
    n_tests = 0;
    nrst = 1'b0;
    {wd_timer_mode, fetch_internal, pm_access_req, wr, rd} = 5'b0_0000;
    wd_period_cfg = `WD_PERIOD_OFF;
    processor_mode_cfg = 3'b111;
    master_clear_pin = 1'b1;
    osc_mode_cfg = 2'b01;
    int_enable = 11'h000;
    int_flag = 11'h000;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    t_power_up();
    t_sleep_wake();
    t_pending_wake();
    t_wd_timeout();
    t_timer_mode();
    t_crystal_wake();
    t_master_clear();
    t_code_protect();
    wrap_up();
  end
endmodule // watchdog_sleep_wake_control_tb_top
